/* design/sfd_map.svh */
// sfd_map.svh: offsets, field positions, reset values and codes of the
// ddr read block.
// assumes: included by bare name from the package file only.
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SFD_OFF_CTRL        4'h0
`define SFD_OFF_DUMMY       4'h4
`define SFD_OFF_STAT        4'h8
`define SFD_OFF_ADDR        4'hc

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define SFD_CTRL_QPI_BIT    0
`define SFD_CTRL_QE_BIT     1
`define SFD_CTRL_RST        2'h0
`define SFD_DUM_SGL_LSB     0
`define SFD_DUM_DUAL_LSB    4
`define SFD_DUM_QUAD_LSB    8
`define SFD_DUMMY_RST       12'h648
`define SFD_PINS_RST        6'h10

// ----------------------------------------------------------------------
// opcodes and mode nibble
// ----------------------------------------------------------------------
`define SFD_OP_SGL          8'h0d
`define SFD_OP_DUAL         8'hbd
`define SFD_OP_QUAD         8'hed
`define SFD_MODE_CONT       4'ha

// ----------------------------------------------------------------------
// phase lengths, last index: command in sck rises, address in sck edges
// ----------------------------------------------------------------------
`define SFD_CMD_LAST_SPI    5'h07
`define SFD_CMD_LAST_QPI    5'h01
`define SFD_ADDR_LAST_SGL   5'h17
`define SFD_ADDR_LAST_DUAL  5'h0b
`define SFD_ADDR_LAST_QUAD  5'h05

`endif

/* design/sfd_pkg.sv */
// sfd_pkg.sv: types shared by the ddr read block.
// assumes: sfd_map.svh is on the include path.
`include "sfd_map.svh"

package sfd_pkg;

	// pins sampled from the host side
	typedef struct packed {
		logic       sck;
		logic       cs_n;
		logic [3:0] io;
	} sfd_pins_t;

	// transaction phases, gray along the usual path
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_CMD    = 3'h1,
		ST_ADDR   = 3'h3,
		ST_DUMMY  = 3'h2,
		ST_DATA   = 3'h6,
		ST_IGNORE = 3'h7
	} sfd_state_t;

	// read variant; bit 1 set means four lines wide
	typedef enum logic [1:0] {
		KIND_SGL     = 2'h0,
		KIND_DUAL    = 2'h1,
		KIND_QUAD    = 2'h2,
		KIND_QPI_SGL = 2'h3
	} sfd_kind_t;

endpackage

/* design/sfd_pin_sync.sv */
// sfd_pin_sync.sv: two-flop synchroniser for the host pins plus sck edges.
// assumes: pins are asynchronous to i_clk_sys; sck well below half its rate.
`timescale 1ns/1ps

module sfd_pin_sync
	import sfd_pkg::*;
(
	// clock and reset
	input  wire logic      i_clk_sys,
	input  wire logic      i_resetn,
	// raw pins
	input  wire sfd_pins_t i_pins,
	// synchronised pins and sck edges
	output sfd_pins_t      o_pins,
	output logic           o_sck_rise,
	output logic           o_sck_fall
);

	sfd_pins_t meta_ff;
	sfd_pins_t sync_ff;
	logic      sck_prev_ff;

	// ------------------------------------------------------------------
	// two stages, then one more for sck edges
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_ff     <= `SFD_PINS_RST;
			sync_ff     <= `SFD_PINS_RST;
			sck_prev_ff <= 1'b0;
		end else begin
			meta_ff     <= i_pins;
			sync_ff     <= meta_ff;
			sck_prev_ff <= sync_ff.sck;
		end
	end

	assign o_pins     = sync_ff;
	assign o_sck_rise = sync_ff.sck & ~sck_prev_ff;
	assign o_sck_fall = ~sync_ff.sck & sck_prev_ff;

endmodule

/* design/sfd_ddr_read.sv */
// sfd_ddr_read.sv: double-rate read path of the serial flash, single,
// dual and quad lines, one- and four-bit command modes, continuous read on dual and quad reads.
// assumes: host pins are asynchronous; array read port answers in the
// same cycle; busy flag comes from the program/erase engine on i_clk_sys.
`timescale 1ns/1ps

module sfd_ddr_read
	import sfd_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_resetn,
	// avalon-mm slave
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	// flash pins
	input  wire logic        i_sck,
	input  wire logic        i_cs_n,
	input  wire logic [3:0]  i_io,
	output logic [3:0]       o_io,
	output logic [3:0]       o_io_oe,
	// array and engine
	input  wire logic        i_busy_flag,
	output logic [23:0]      o_mem_addr,
	input  wire logic [7:0]  i_mem_rdata,
	output logic             o_continuous_read_mode
);

	// ------------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------------
	function automatic logic [4:0] addr_last(input sfd_kind_t k);
		if (k == KIND_SGL)
			return `SFD_ADDR_LAST_SGL;
		else if (k == KIND_DUAL)
			return `SFD_ADDR_LAST_DUAL;
		else
			return `SFD_ADDR_LAST_QUAD;
	endfunction

	function automatic logic [4:0] chunk_last(input sfd_kind_t k);
		if (k == KIND_SGL)
			return 5'h07;
		else if (k == KIND_DUAL)
			return 5'h03;
		else
			return 5'h01;
	endfunction

	// shift in one edge worth of bits at the width of the read
	function automatic logic [23:0] shift_in(input logic [23:0] v,
	                                        input sfd_kind_t k,
	                                        input logic [3:0] io);
		if (k == KIND_SGL)
			return {v[22:0], io[0]};
		else if (k == KIND_DUAL)
			return {v[21:0], io[1:0]};
		else
			return {v[19:0], io};
	endfunction

	// decoded opcode: bit 2 valid, bits 1:0 kind
	function automatic logic [2:0] op_decode(input logic [7:0] op,
	                                        input logic four_bit_command_mode,
	                                        input logic qe);
		if (four_bit_command_mode && op == `SFD_OP_SGL)
			return {1'b1, KIND_QPI_SGL};
		else if (four_bit_command_mode && op == `SFD_OP_QUAD)
			return {1'b1, KIND_QUAD};
		else if (!four_bit_command_mode && op == `SFD_OP_SGL)
			return {1'b1, KIND_SGL};
		else if (!four_bit_command_mode && op == `SFD_OP_DUAL)
			return {1'b1, KIND_DUAL};
		else if (!four_bit_command_mode && op == `SFD_OP_QUAD && qe)
			return {1'b1, KIND_QUAD};
		else
			return 3'h0;
	endfunction

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	sfd_pins_t   raw_pins;
	sfd_pins_t   pin;
	logic        sck_rise;
	logic        sck_fall;
	logic        sck_edge;
	sfd_state_t  state_ff;
	sfd_state_t  nxt_state;
	logic [4:0]  cnt_ff;
	logic [4:0]  nxt_cnt;
	sfd_kind_t   kind_ff;
	sfd_kind_t   nxt_kind;
	logic [7:0]  cmd_sh_ff;
	logic [7:0]  op_now;
	logic [2:0]  op_dec;
	logic [4:0]  cmd_end;
	logic [23:0] mode_shift;
	logic [23:0] addr_ff;
	logic [7:0]  mode_ff;
	logic [7:0]  nxt_mode;
	logic [7:0]  sh_ff;
	logic [7:0]  nxt_sh;
	logic        start_data;
	logic        byte_step;
	logic        cont_ff;
	logic [3:0]  io_ff;
	logic [3:0]  oe_ff;
	logic [3:0]  dummy_sel;
	logic [4:0]  dummy_last;
	logic [1:0]  ctrl_ff;
	logic [11:0] dummy_ff;
	logic        ack_ff;
	logic [31:0] rdata_ff;
	logic        avs_req;

	// ------------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------------
	assign raw_pins = '{sck: i_sck, cs_n: i_cs_n, io: i_io};

	sfd_pin_sync u_sync (
		.i_clk_sys  (i_clk_sys),
		.i_resetn   (i_resetn),
		.i_pins     (raw_pins),
		.o_pins     (pin),
		.o_sck_rise (sck_rise),
		.o_sck_fall (sck_fall)
	);

	assign sck_edge = sck_rise | sck_fall;

	// ------------------------------------------------------------------
	// phase control
	// ------------------------------------------------------------------
	assign op_now = ctrl_ff[`SFD_CTRL_QPI_BIT] ? {cmd_sh_ff[3:0], pin.io}
	                                           : {cmd_sh_ff[6:0], pin.io[0]};
	assign op_dec = op_decode(cmd_sh_ff, ctrl_ff[`SFD_CTRL_QPI_BIT],
	                          ctrl_ff[`SFD_CTRL_QE_BIT]);
	// rise count at which the opcode is complete
	assign cmd_end = (ctrl_ff[`SFD_CTRL_QPI_BIT] ? `SFD_CMD_LAST_QPI : `SFD_CMD_LAST_SPI)
	                 + 5'h01;

	always_comb begin
		if (kind_ff == KIND_SGL)
			dummy_sel = dummy_ff[`SFD_DUM_SGL_LSB +: 4];
		else if (kind_ff == KIND_DUAL)
			dummy_sel = dummy_ff[`SFD_DUM_DUAL_LSB +: 4];
		else
			dummy_sel = dummy_ff[`SFD_DUM_QUAD_LSB +: 4];
		// two edges per dummy clock; zero is taken as one
		if (dummy_sel == 4'h0)
			dummy_last = 5'h01;
		else
			dummy_last = {dummy_sel, 1'b0} - 5'h01;
	end

	always_comb begin
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_kind   = kind_ff;
		start_data = 1'b0;
		byte_step  = 1'b0;
		if (pin.cs_n) begin
			nxt_state = ST_IDLE;
			nxt_cnt   = 5'h00;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					nxt_cnt = 5'h00;
					if (cont_ff && i_busy_flag)
						nxt_state = ST_IGNORE;
					else if (cont_ff)
						nxt_state = ST_ADDR;
					else
						nxt_state = ST_CMD;
				end
				ST_CMD: begin
					// decode on the fall closing the last opcode clock
					if (sck_rise) begin
						nxt_cnt = cnt_ff + 5'h01;
					end else if (sck_fall && cnt_ff == cmd_end) begin
						nxt_cnt = 5'h00;
						if (!op_dec[2] || i_busy_flag) begin
							nxt_state = ST_IGNORE;
						end else begin
							nxt_state = ST_ADDR;
							nxt_kind  = sfd_kind_t'(op_dec[1:0]);
						end
					end
				end
				ST_ADDR: begin
					if (sck_edge) begin
						nxt_cnt = cnt_ff + 5'h01;
						if (cnt_ff == addr_last(kind_ff)) begin
							nxt_state = ST_DUMMY;
							nxt_cnt   = 5'h00;
						end
					end
				end
				ST_DUMMY: begin
					if (sck_edge) begin
						nxt_cnt = cnt_ff + 5'h01;
						if (cnt_ff == dummy_last) begin
							nxt_state  = ST_DATA;
							nxt_cnt    = 5'h00;
							start_data = 1'b1;
						end
					end
				end
				ST_DATA: begin
					if (sck_edge) begin
						nxt_cnt = cnt_ff + 5'h01;
						if (cnt_ff == chunk_last(kind_ff)) begin
							nxt_cnt   = 5'h00;
							byte_step = 1'b1;
						end
					end
				end
				default: begin
					nxt_state = ST_IGNORE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= 5'h00;
			kind_ff  <= KIND_SGL;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			kind_ff  <= nxt_kind;
		end
	end

	// ------------------------------------------------------------------
	// opcode shifter
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn)
			cmd_sh_ff <= 8'h00;
		else if (state_ff != ST_CMD)
			cmd_sh_ff <= 8'h00;
		else if (sck_rise)
			cmd_sh_ff <= op_now;
	end

	// ------------------------------------------------------------------
	// address capture and increment
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn)
			addr_ff <= 24'h000000;
		else if (state_ff == ST_ADDR && sck_edge)
			addr_ff <= shift_in(addr_ff, kind_ff, pin.io);
		else if (start_data || byte_step)
			addr_ff <= addr_ff + 24'h000001;
	end

	assign o_mem_addr = addr_ff;

	// ------------------------------------------------------------------
	// mode byte and continuous read
	// ------------------------------------------------------------------
	assign mode_shift = shift_in({16'h0000, mode_ff}, kind_ff, pin.io);

	always_comb begin
		nxt_mode = mode_ff;
		if (state_ff == ST_DUMMY && sck_edge && cnt_ff <= chunk_last(kind_ff))
			nxt_mode = mode_shift[7:0];
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn)
			mode_ff <= 8'h00;
		else if (state_ff == ST_ADDR)
			mode_ff <= 8'h00;
		else
			mode_ff <= nxt_mode;
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn)
			cont_ff <= 1'b0;
		else if (start_data)
			cont_ff <= (kind_ff == KIND_DUAL || kind_ff == KIND_QUAD) &&
			           nxt_mode[7:4] == `SFD_MODE_CONT;
	end

	assign o_continuous_read_mode = cont_ff;

	// ------------------------------------------------------------------
	// data shifter and pin drive
	// ------------------------------------------------------------------
	always_comb begin
		nxt_sh = sh_ff;
		if (start_data || byte_step)
			nxt_sh = i_mem_rdata;
		else if (state_ff == ST_DATA && sck_edge) begin
			if (kind_ff == KIND_SGL)
				nxt_sh = {sh_ff[6:0], 1'b0};
			else if (kind_ff == KIND_DUAL)
				nxt_sh = {sh_ff[5:0], 2'b00};
			else
				nxt_sh = {sh_ff[3:0], 4'h0};
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			sh_ff <= 8'h00;
			io_ff <= 4'h0;
			oe_ff <= 4'h0;
		end else begin
			sh_ff <= nxt_sh;
			if (kind_ff == KIND_SGL)
				io_ff <= {2'b00, nxt_sh[7], 1'b0};
			else if (kind_ff == KIND_DUAL)
				io_ff <= {2'b00, nxt_sh[7:6]};
			else
				io_ff <= nxt_sh[7:4];
			if (nxt_state != ST_DATA)
				oe_ff <= 4'h0;
			else if (kind_ff == KIND_SGL)
				oe_ff <= 4'h2;
			else if (kind_ff == KIND_DUAL)
				oe_ff <= 4'h3;
			else
				oe_ff <= 4'hf;
		end
	end

	assign o_io    = io_ff;
	assign o_io_oe = oe_ff;

	// ------------------------------------------------------------------
	// avalon-mm registers
	// ------------------------------------------------------------------
	assign avs_req           = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = avs_req & ~ack_ff;
	assign o_avs_readdata    = rdata_ff;

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn)
			ack_ff <= 1'b0;
		else
			ack_ff <= avs_req & ~ack_ff;
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_ff  <= `SFD_CTRL_RST;
			dummy_ff <= `SFD_DUMMY_RST;
		end else if (i_avs_write && ack_ff) begin
			if (i_avs_address == `SFD_OFF_CTRL && i_avs_byteenable[0])
				ctrl_ff <= i_avs_writedata[1:0];
			else if (i_avs_address == `SFD_OFF_DUMMY) begin
				if (i_avs_byteenable[0])
					dummy_ff[7:0] <= i_avs_writedata[7:0];
				if (i_avs_byteenable[1])
					dummy_ff[11:8] <= i_avs_writedata[11:8];
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn)
			rdata_ff <= 32'h00000000;
		else if (i_avs_read && !ack_ff) begin
			if (i_avs_address == `SFD_OFF_CTRL)
				rdata_ff <= {30'h00000000, ctrl_ff};
			else if (i_avs_address == `SFD_OFF_DUMMY)
				rdata_ff <= {20'h00000, dummy_ff};
			else if (i_avs_address == `SFD_OFF_STAT)
				rdata_ff <= {25'h0000000, state_ff, kind_ff, i_busy_flag, cont_ff};
			else if (i_avs_address == `SFD_OFF_ADDR)
				rdata_ff <= {8'h00, addr_ff};
			else
				rdata_ff <= 32'h00000000;
		end
	end

endmodule

/* verif/sfd_ddr_read_monitor.sv */
// sfd_ddr_read_monitor.sv: port checker for the ddr read block.
// assumes: bound to sfd_ddr_read, one clock domain.
`timescale 1ns/1ps

module sfd_ddr_read_chk (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_resetn,
	// link and engine
	input  wire logic        i_sck,
	input  wire logic        i_cs_n,
	input  wire logic        i_busy_flag,
	input  wire logic [3:0]  o_io,
	input  wire logic [3:0]  o_io_oe,
	input  wire logic [23:0] o_mem_addr,
	input  wire logic        o_continuous_read_mode
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	logic       bsy_ff;
	logic       sck_ff;
	logic [3:0] edg_ff;

	// busy all through the frame; cycles since sck moved
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			bsy_ff <= 1'b0;
			sck_ff <= 1'b0;
			edg_ff <= 4'hf;
		end else begin
			bsy_ff <= i_cs_n ? i_busy_flag : (bsy_ff & i_busy_flag);
			sck_ff <= i_sck;
			edg_ff <= (i_sck != sck_ff) ? 4'h0 : ((edg_ff == 4'hf) ? 4'hf : edg_ff + 4'h1);
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_busy_quiet;
		bsy_ff && !i_cs_n |-> o_io_oe == 4'h0;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet)
		else $error("lines driven while busy");
	property p_cs_release;
		i_cs_n [*8] |-> o_io_oe == 4'h0;
	endproperty
	a_cs_release: assert property (p_cs_release)
		else $error("lines driven after select high");
	property p_oe_code;
		o_io_oe != 4'h0 |-> o_io_oe inside {4'h2, 4'h3, 4'hf};
	endproperty
	a_oe_code: assert property (p_oe_code)
		else $error("bad output lane set");
	property p_oe_hold;
		o_io_oe != 4'h0 && $past(o_io_oe) != 4'h0 |-> $stable(o_io_oe);
	endproperty
	a_oe_hold: assert property (p_oe_hold)
		else $error("lane width changed in data phase");
	property p_addr_step;
		$changed(o_mem_addr) && $past(o_io_oe) != 4'h0 |-> o_mem_addr == $past(o_mem_addr) + 24'h1;
	endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("address did not step by one");
	property p_data_edge;
		$changed(o_io) && $past(o_io_oe) != 4'h0 && o_io_oe != 4'h0 |-> edg_ff < 4'h8;
	endproperty
	a_data_edge: assert property (p_data_edge)
		else $error("data moved without sck edge");
	property p_cont_entry;
		$changed(o_continuous_read_mode) |-> ##[0:8] o_io_oe != 4'h0;
	endproperty
	a_cont_entry: assert property (p_cont_entry)
		else $error("continuous mode changed outside data entry");
	property p_rst_out;
		$rose(i_resetn) |-> o_io_oe == 4'h0 && !o_continuous_read_mode && o_mem_addr == 24'h0;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs not at reset values");
endmodule

bind sfd_ddr_read sfd_ddr_read_chk i_sfd_ddr_read_chk (
	.i_clk_sys              (i_clk_sys),
	.i_resetn               (i_resetn),
	.i_sck                  (i_sck),
	.i_cs_n                 (i_cs_n),
	.i_busy_flag            (i_busy_flag),
	.o_io                   (o_io),
	.o_io_oe                (o_io_oe),
	.o_mem_addr             (o_mem_addr),
	.o_continuous_read_mode (o_continuous_read_mode)
);

/* verif/sfd_host_model.sv */
// sfd_host_model.sv: behavioural host controller issuing ddr reads.
// assumes: the bench resolves the data lines and returns them on i_io.
`timescale 1ns/1ps

module sfd_host_model (
	// link pins driven by the host
	output logic            o_sck,
	output logic            o_cs_n,
	output logic [3:0]      o_io,
	// resolved lines and device enables
	input  wire logic [3:0] i_io,
	input  wire logic [3:0] i_oe
);
	logic       drove;
	logic [7:0] got [8];

	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'h0;
		drove = 1'b0;
	end

	// notes any device drive within a frame
	always @(i_oe) begin
		if (i_oe != 4'h0) begin
			drove = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// frame tasks
	// ----------------------------------------------------------------
	task automatic put(input logic [3:0] v);
		o_io = v;
		#12;
		o_sck = ~o_sck;
		#12;
	endtask

	// q four-bit commands, w lanes, sk skip opcode, n dummies, nb bytes
	task automatic rd(input logic q, input int w, input logic sk, input logic [7:0] op,
		input logic [23:0] a, input int n, input logic [7:0] md, input int nb);
		logic [31:0] sh;
		logic [7:0]  b;
		logic [3:0]  v;
		drove = 1'b0;
		o_cs_n = 1'b0;
		#20;
		for (int i = 0; i < (q ? 4 : 16) && !sk; i++) begin
			put(q ? (i < 2 ? op[7:4] : op[3:0]) : {3'h0, op[7 - i / 2]});
		end
		sh = {a, 8'h0};
		for (int i = 0; i < 24 / w; i++) begin
			put(4'(sh[31:28] >> (4 - w)));
			sh = sh << w;
		end
		sh = {md, 24'h0};
		for (int i = 0; i < 2 * n; i++) begin
			put(i < 8 / w ? 4'(sh[31:28] >> (4 - w)) : ~o_io);
			sh = sh << w;
		end
		#12;
		for (int i = 0; i < nb * 8 / w; i++) begin
			#12;
			v = (w == 1) ? {3'h0, i_io[1]} : ((w == 2) ? {2'h0, i_io[1:0]} : i_io);
			b = 8'((b << w) | v);
			if ((i + 1) % (8 / w) == 0) got[i * w / 8] = b;
			o_io = ~o_io;
			o_sck = ~o_sck;
			#12;
		end
		o_cs_n = 1'b1;
		#60;
	endtask
endmodule

/* verif/sfd_ddr_read_test.sv */
// sfd_ddr_read_test.sv: self-checking bench for the ddr read block.
// assumes: host model and checker compiled first; array is a fixed pattern.
`timescale 1ns/1ps

module sfd_ddr_read_test;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic        busy = 1'b0;
	logic [31:0] r;
	wire  [31:0] rdat;
	wire         wait_r;
	wire         sck;
	wire         cs_n;
	wire  [3:0]  h_io;
	wire  [3:0]  d_io;
	wire  [3:0]  d_oe;
	wire  [3:0]  io_w;
	wire  [23:0] maddr;
	wire  [7:0]  mdat;
	wire         cont;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	function automatic logic [7:0] mv(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ 8'h3c;
	endfunction

	always #2.5 clk = ~clk;
	assign io_w = (d_io & d_oe) | (h_io & ~d_oe);
	assign mdat = mv(maddr);

	sfd_ddr_read i_sfd_ddr_read (.i_clk_sys(clk), .i_resetn(rstn), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wait_r), .i_sck(sck), .i_cs_n(cs_n),
		.i_io(io_w), .o_io(d_io), .o_io_oe(d_oe), .i_busy_flag(busy), .o_mem_addr(maddr),
		.i_mem_rdata(mdat), .o_continuous_read_mode(cont));
	sfd_host_model i_sfd_host_model (.o_sck(sck), .o_cs_n(cs_n), .o_io(h_io), .i_io(io_w),
		.i_oe(d_oe));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, s, e);
		end
	endtask

	task automatic conclude;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wdat <= d;
		@(posedge clk);
		while (wait_r !== 1'b0) @(posedge clk);
		r = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic fr(input logic q, input int w, input logic sk, input logic [7:0] op,
		input logic [23:0] a, input int n, input logic [7:0] md, input int nb, input logic ok);
		i_sfd_host_model.rd(q, w, sk, op, a, n, md, nb);
		for (int k = 0; k < nb && ok; k++) begin
			chk({24'h0, i_sfd_host_model.got[k]}, {24'h0, mv(24'(a + k))});
		end
		if (!ok) chk({31'h0, i_sfd_host_model.drove}, 32'h0);
		chk({28'h0, d_oe}, 32'h0);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			conclude();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		acc(1'b0, 4'h4, 32'h0);
		chk(r, 32'h648);
		acc(1'b0, 4'h0, 32'h0);
		chk(r, 32'h0);
		fr(0, 1, 0, 8'h0d, 24'hfffffe, 8, 8'hff, 4, 1);
		fr(0, 2, 0, 8'hbd, 24'h123456, 4, 8'ha5, 2, 1);
		chk({31'h0, cont}, 32'h1);
		fr(0, 2, 1, 8'h00, 24'h00abcd, 4, 8'h5f, 2, 1);
		chk({31'h0, cont}, 32'h0);
		fr(0, 4, 0, 8'hed, 24'h000100, 6, 8'ha0, 1, 0);
		acc(1'b1, 4'h0, 32'h2);
		fr(0, 4, 0, 8'hed, 24'h7ffff0, 6, 8'ha3, 3, 1);
		chk({31'h0, cont}, 32'h1);
		fr(0, 4, 1, 8'h00, 24'h00fff0, 6, 8'h00, 2, 1);
		chk({31'h0, cont}, 32'h0);
		acc(1'b1, 4'h4, 32'h325);
		acc(1'b1, 4'h0, 32'h3);
		fr(1, 4, 0, 8'h0d, 24'h000200, 3, 8'ha0, 2, 1);
		chk({31'h0, cont}, 32'h0);
		fr(1, 4, 0, 8'hed, 24'h000300, 3, 8'ha0, 2, 1);
		chk({31'h0, cont}, 32'h1);
		fr(1, 4, 1, 8'h00, 24'h000400, 3, 8'h11, 2, 1);
		chk({31'h0, cont}, 32'h0);
		acc(1'b1, 4'h0, 32'h0);
		fr(0, 1, 0, 8'h0d, 24'h000500, 5, 8'h00, 1, 1);
		fr(0, 2, 0, 8'hbd, 24'h000600, 2, 8'h00, 1, 1);
		@(posedge clk);
		busy <= 1'b1;
		fr(0, 2, 0, 8'hbd, 24'h000700, 2, 8'h00, 1, 0);
		@(posedge clk);
		busy <= 1'b0;
		fr(0, 2, 0, 8'hbd, 24'h000780, 2, 8'ha0, 1, 1);
		@(posedge clk);
		busy <= 1'b1;
		fr(0, 2, 1, 8'h00, 24'h0007c0, 2, 8'ha0, 1, 0);
		chk({31'h0, cont}, 32'h1);
		@(posedge clk);
		busy <= 1'b0;
		rstn <= 1'b0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		acc(1'b0, 4'h4, 32'h0);
		chk(r, 32'h648);
		chk({31'h0, cont}, 32'h0);
		fr(0, 1, 0, 8'h0d, 24'h000800, 8, 8'h00, 1, 1);
		conclude();
	end
endmodule
